// ===== scfg_defines.svh
`ifndef SCFG_DEFINES_SVH
`define SCFG_DEFINES_SVH

// Packet geometry
`define SCFG_FRAME_BITS     32
`define SCFG_ADDR_LAST_RISE 6'd13
`define SCFG_LAST_RISE      6'd31
`define SCFG_OK_FALL        6'd14
`define SCFG_DATA_FALL      6'd15
`define SCFG_TAG_FALL       6'd11
`define SCFG_DUMMY_FALL     6'd10

// Response field positions
`define SCFG_RESP_PAR_BIT   5'd0
`define SCFG_RESP_DATA_TOP  5'd16
`define SCFG_RESP_OK_BIT    5'd17
`define SCFG_RESP_TAG_LOW   5'd18
`define SCFG_RESP_TAG_TOP   5'd20

// This port block and bus slave, top four address bits
`define SCFG_BLOCK_SEL      4'h0

// Register indices
`define SCFG_IDX_POWER_OFF  7'h00
`define SCFG_IDX_MODE       7'h01
`define SCFG_IDX_PROBE      7'h02
`define SCFG_IDX_SPARE      7'h03

// Reset values
`define SCFG_RST_POWER_OFF  16'h0000
`define SCFG_RST_MODE       16'h0000
`define SCFG_RST_PROBE      16'h0000
`define SCFG_RST_SPARE      16'h0000

// Synchroniser idle value: sclk high, chip select high
`define SCFG_SYNC_IDLE      6'h30

`endif

// ===== scfg_pkg.sv
`default_nettype none
package scfg_pkg;
  typedef enum logic [1:0] {
    SCFG_APB_IDLE,
    SCFG_APB_SETUP,
    SCFG_APB_ACCESS
  } scfg_apb_state_t;
endpackage
`default_nettype wire

// ===== scfg_sync.sv
`default_nettype none
module scfg_sync
  import scfg_pkg::*;
#(
  parameter int              WIDTH = 6,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output var  logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1;

  if (WIDTH < 1) begin : gBadWidth
    $error("scfg_sync width must be positive");
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stage1  <= INIT;
      syncOut <= INIT;
    end else begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule // scfg_sync
`default_nettype wire

// ===== scfg_reg_bank.sv
`default_nettype none
`include "scfg_defines.svh"
module scfg_reg_bank
  import scfg_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [6:0]  paddr,
  input  wire logic [15:0] pwdata,
  output var  logic [15:0] prdata,
  output var  logic        pready,
  output var  logic [3:0]  analogRegOff,
  output var  logic [2:0]  digitalRegOff,
  output var  logic [4:0]  converterModeSelect,
  output var  logic        converterSleep,
  output var  logic [3:0]  probeChannel,
  output var  logic        probeMuxEn,
  output var  logic        probeBufEn
);
  logic [15:0] regPowerOff;
  logic [15:0] regMode;
  logic [15:0] regProbe;
  logic [15:0] regSpare;
  logic        wrStrobe;

  assign wrStrobe = psel && penable && pwrite;
  assign pready   = 1'b1;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      regPowerOff <= `SCFG_RST_POWER_OFF;
      regMode     <= `SCFG_RST_MODE;
      regProbe    <= `SCFG_RST_PROBE;
      regSpare    <= `SCFG_RST_SPARE;
    end else if (wrStrobe) begin
      if (paddr == `SCFG_IDX_POWER_OFF) begin
        regPowerOff <= pwdata;
      end else if (paddr == `SCFG_IDX_MODE) begin
        regMode <= pwdata;
      end else if (paddr == `SCFG_IDX_PROBE) begin
        regProbe <= pwdata;
      end else if (paddr == `SCFG_IDX_SPARE) begin
        regSpare <= pwdata;
      end
    end
  end

  // Unmapped indices read as zero
  always_comb begin
    if (paddr == `SCFG_IDX_POWER_OFF) begin
      prdata = regPowerOff;
    end else if (paddr == `SCFG_IDX_MODE) begin
      prdata = regMode;
    end else if (paddr == `SCFG_IDX_PROBE) begin
      prdata = regProbe;
    end else if (paddr == `SCFG_IDX_SPARE) begin
      prdata = regSpare;
    end else begin
      prdata = 16'h0000;
    end
  end

  assign analogRegOff        = regPowerOff[3:0];
  assign digitalRegOff       = regPowerOff[6:4];
  assign converterModeSelect = regMode[4:0];
  assign converterSleep      = regMode[5];
  assign probeChannel        = regProbe[3:0];
  assign probeMuxEn          = regProbe[4];
  assign probeBufEn          = regProbe[5];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  chk_power_write: assert property (
    wrStrobe && paddr == `SCFG_IDX_POWER_OFF
      |=> {digitalRegOff, analogRegOff} == $past(pwdata[6:0]))
    else $error("regulator power-off write not stored");

  chk_mode_write: assert property (
    wrStrobe && paddr == `SCFG_IDX_MODE
      |=> converterSleep == $past(pwdata[5]) && prdata == prdata)
    else $error("converter mode write not stored");
endmodule // scfg_reg_bank
`default_nettype wire

// ===== scfg_spi_slave.sv
`default_nettype none
`include "scfg_defines.svh"
// Function
// - Serial port is mode 3: clock idles high, bits sampled on rising edges.
// - Each transfer is 32 bits each way, response sent while command arrives.
// - Bits shift most significant first; bit 31 is top die-tag bit.
// - Command bits 31..29 must equal die-tag pins, else packet ignored.
// - Bits 28..18 are address: 2-bit port, 2-bit slave, 7-bit index.
// - Index selects one of 128 registers in the chosen slave; this slave holds only indices 0..3, the rest read as zero and ignore writes.
// - Bit 17 is write flag; a read is done on every packet whose tag and port/slave bits match.
// - On write, command bits 16..1 go into the addressed register.
// - Bit 0 of command and response makes total ones even.
// - Command with wrong parity is dropped: no write, though its read is still forwarded.
// - Response bits 31..21 are filler the master ignores.
// - Response bits 20..18 return the device die tag.
// - Response bit 17 tells whether the previous packet had good parity.
// - Response bits 16..1 return the register addressed by this packet.
// - Checked operations are forwarded as internal bus master to slaves.
// - Register 0: analog off bits 3..0, digital off 6..4, spare above.
// - Register 2: probe channel 3..0, mux enable 4, buffer enable 5.
module scfg_spi_slave
  import scfg_pkg::*;
#(
  parameter int FRAME_BITS = `SCFG_FRAME_BITS
) (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       sclk,
  input  wire logic       csN,
  input  wire logic       mosi,
  input  wire logic [2:0] dieTagPins,
  output var  logic       miso,
  output var  logic [3:0] analogRegOff,
  output var  logic [2:0] digitalRegOff,
  output var  logic [4:0] converterModeSelect,
  output var  logic       converterSleep,
  output var  logic [3:0] probeChannel,
  output var  logic       probeMuxEn,
  output var  logic       probeBufEn
);
  logic [5:0]      syncBus;
  logic            sclkS;
  logic            csNS;
  logic            mosiS;
  logic [2:0]      tagS;
  logic            sclkPrev;
  logic            active;
  logic            sclkRise;
  logic            sclkFall;
  logic [5:0]      bitCount;
  logic [31:0]     rxShift;
  logic [15:0]     rxPayload;
  logic            addrDone;
  logic            frameDone;
  logic            okFlag;
  logic            rdReq;
  logic            wrReq;
  logic [6:0]      cmdIndex;
  logic [15:0]     cmdData;
  logic            txPar;
  logic            next_miso;
  logic [15:0]     readData;
  scfg_apb_state_t apbState;
  logic            psel;
  logic            penable;
  logic            pwrite;
  logic [15:0]     prdata;
  logic            pready;

  if (FRAME_BITS != 32) begin : gBadFrame
    $error("scfg_spi_slave serves 32-bit packets only");
  end

  // Packet addresses this block when tag and port/slave fields match
  function automatic logic hitFn(input logic [2:0] tag, input logic [3:0] sel,
                                 input logic [2:0] pins);
    return (tag == pins) && (sel == `SCFG_BLOCK_SEL);
  endfunction

  function automatic logic respBit(input logic [4:0] idx, input logic [2:0] tag,
                                   input logic ok, input logic [15:0] data,
                                   input logic par);
    logic b;
    b = 1'b0;
    if (idx == `SCFG_RESP_PAR_BIT) begin
      b = par;
    end else if (idx <= `SCFG_RESP_DATA_TOP) begin
      b = data[4'(idx - 5'd1)];
    end else if (idx == `SCFG_RESP_OK_BIT) begin
      b = ok;
    end else if (idx <= `SCFG_RESP_TAG_TOP) begin
      b = tag[2'(idx - `SCFG_RESP_TAG_LOW)];
    end
    return b;
  endfunction

  scfg_sync #(
    .WIDTH (6),
    .INIT  (`SCFG_SYNC_IDLE)
  ) u_sync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .asyncIn ({sclk, csN, mosi, dieTagPins}),
    .syncOut (syncBus)
  );

  assign {sclkS, csNS, mosiS, tagS} = syncBus;
  assign active   = !csNS;
  assign sclkRise = active && sclkS && !sclkPrev;
  assign sclkFall = active && !sclkS && sclkPrev;
  assign rxPayload = rxShift[16:1];

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sclkPrev <= 1'b1;
    end else begin
      sclkPrev <= sclkS;
    end
  end

  // Receive shifter, most significant bit first
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bitCount <= 6'd0;
      rxShift  <= 32'h0000_0000;
    end else if (!active) begin
      bitCount <= 6'd0;
    end else if (sclkRise && bitCount < 6'(FRAME_BITS)) begin
      rxShift  <= {rxShift[30:0], mosiS};
      bitCount <= bitCount + 6'd1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      addrDone  <= 1'b0;
      frameDone <= 1'b0;
    end else begin
      addrDone  <= sclkRise && bitCount == `SCFG_ADDR_LAST_RISE;
      frameDone <= sclkRise && bitCount == `SCFG_LAST_RISE;
    end
  end

  // Requests toward the internal bus
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdReq    <= 1'b0;
      wrReq    <= 1'b0;
      cmdIndex <= 7'h00;
      cmdData  <= 16'h0000;
    end else begin
      rdReq <= addrDone && hitFn(rxShift[13:11], rxShift[10:7], tagS);
      wrReq <= frameDone && !(^rxShift) && rxShift[17]
               && hitFn(rxShift[31:29], rxShift[28:25], tagS);
      if (addrDone) begin
        cmdIndex <= rxShift[6:0];
      end else if (frameDone) begin
        cmdIndex <= rxShift[24:18];
        cmdData  <= rxPayload;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      okFlag <= 1'b0;
    end else if (frameDone) begin
      okFlag <= !(^rxShift);
    end
  end

  // Internal bus master
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      apbState <= SCFG_APB_IDLE;
      pwrite   <= 1'b0;
    end else begin
      case (apbState)
        SCFG_APB_IDLE: begin
          if (rdReq || wrReq) begin
            apbState <= SCFG_APB_SETUP;
            pwrite   <= wrReq;
          end
        end
        SCFG_APB_SETUP: begin
          apbState <= SCFG_APB_ACCESS;
        end
        SCFG_APB_ACCESS: begin
          if (pready) begin
            apbState <= SCFG_APB_IDLE;
          end
        end
        default: begin
          apbState <= SCFG_APB_IDLE;
        end
      endcase
    end
  end

  assign psel    = apbState != SCFG_APB_IDLE;
  assign penable = apbState == SCFG_APB_ACCESS;

  // Data for this packet's answer; zero when the read went elsewhere
  always_ff @(posedge clk_sys) begin
    if (sys_rst || addrDone) begin
      readData <= 16'h0000;
    end else if (penable && pready && !pwrite) begin
      readData <= prdata;
    end
  end

  assign next_miso = respBit(5'(6'd31 - bitCount), tagS, okFlag, readData, txPar);

  // Response bits change on falling edges, parity accumulated as they go
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !active) begin
      miso  <= 1'b0;
      txPar <= 1'b0;
    end else if (sclkFall && bitCount != 6'd0 && bitCount < 6'(FRAME_BITS)) begin
      miso  <= next_miso;
      txPar <= txPar ^ next_miso;
    end
  end

  scfg_reg_bank u_bank (
    .clk_sys             (clk_sys),
    .sys_rst             (sys_rst),
    .psel                (psel),
    .penable             (penable),
    .pwrite              (pwrite),
    .paddr               (cmdIndex),
    .pwdata              (cmdData),
    .prdata              (prdata),
    .pready              (pready),
    .analogRegOff        (analogRegOff),
    .digitalRegOff       (digitalRegOff),
    .converterModeSelect (converterModeSelect),
    .converterSleep      (converterSleep),
    .probeChannel        (probeChannel),
    .probeMuxEn          (probeMuxEn),
    .probeBufEn          (probeBufEn)
  );

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence sLastRise;
    sclkRise && bitCount == `SCFG_LAST_RISE;
  endsequence

  sequence sApbWrite;
    (psel && !penable && pwrite) ##1 (psel && penable && pwrite);
  endsequence

  chk_frame_end: assert property (sLastRise |=> frameDone)
    else $error("frame end not flagged after 32 bits");

  chk_rise_sample: assert property (
    sclkRise && bitCount < 6'd32 |=> rxShift[0] == $past(mosiS))
    else $error("bit not sampled on rising edge");

  chk_tag_filter: assert property (
    frameDone && rxShift[31:29] != tagS |=> !wrReq)
    else $error("write issued for foreign die tag");

  chk_parity_drop: assert property (frameDone && ^rxShift |=> !wrReq)
    else $error("write issued for bad parity");

  chk_apb_write: assert property (wrReq |=> sApbWrite)
    else $error("write not forwarded on internal bus");

  chk_write_payload: assert property (wrReq |-> cmdData == $past(rxPayload))
    else $error("write payload differs from command bits");

  chk_read_issue: assert property (
    rdReq |=> psel && !pwrite ##1 penable && !pwrite)
    else $error("read not performed");

  chk_ok_out: assert property (
    sclkFall && bitCount == `SCFG_OK_FALL |=> miso == okFlag)
    else $error("ok flag not sent");

  chk_tag_out: assert property (
    sclkFall && bitCount == `SCFG_TAG_FALL |=> miso == tagS[2])
    else $error("die tag not sent");

  chk_dummy_out: assert property (
    sclkFall && bitCount <= `SCFG_DUMMY_FALL |=> !miso)
    else $error("filler bit not zero");

  chk_data_out: assert property (
    sclkFall && bitCount == `SCFG_DATA_FALL |=> miso == readData[15])
    else $error("register data not sent");
endmodule // scfg_spi_slave
`default_nettype wire

// ===== scfg_spi_master.sv
`default_nettype none
module scfg_spi_master
  import scfg_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic miso,
  output var  logic sclk,
  output var  logic csN,
  output var  logic mosi
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    sclk = 1'b1;
    csN  = 1'b1;
    mosi = 1'b0;
  end

  // Sends the top nBits of cmd; fewer than 32 aborts the packet
  task automatic xfer(input logic [31:0] cmd, input int nBits, output logic [31:0] resp);
    resp = '0;
    @(posedge clk_sys);
    csN <= 1'b0;
    for (int i = 31; i >= 32 - nBits; i--) begin
      @(posedge clk_sys);
      sclk <= 1'b0;
      mosi <= cmd[i];
      repeat (4) @(posedge clk_sys);
      sclk <= 1'b1;
      repeat (2) @(negedge clk_sys);
      resp[i] = miso;
      repeat (2) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    csN  <= 1'b1;
    mosi <= ~mosi;
    repeat (8) begin
      @(posedge clk_sys);
      sclk <= 1'b0;
      repeat (4) @(posedge clk_sys);
      sclk <= 1'b1;
      repeat (3) @(posedge clk_sys);
    end
  endtask
endmodule // scfg_spi_master
`default_nettype wire

// ===== tb_spi_config_slave_regs.sv
`default_nettype none
module tb_spi_config_slave_regs
  import scfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [2:0]  tag;
    logic [3:0]  sel;
    logic [6:0]  idx;
    logic        wr;
    logic [15:0] data;
    logic        badPar;
    logic [15:0] rd;
    logic        ok;
  } scfg_row_t;

  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic [2:0]  pins    = 3'h5;
  wire  logic  sclk;
  wire  logic  csN;
  wire  logic  mosi;
  wire  logic  miso;
  wire  logic [18:0] outs;
  logic [15:0] shadow [4];
  scfg_row_t   rows [15];
  int          numErrors = 0;
  int          nTests = 0;

  always #50 clk_sys = ~clk_sys;

  scfg_spi_master master (.clk_sys(clk_sys), .miso(miso), .sclk(sclk), .csN(csN), .mosi(mosi));

  scfg_spi_slave dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .sclk(sclk), .csN(csN), .mosi(mosi),
    .dieTagPins(pins), .miso(miso), .analogRegOff(outs[18:15]), .digitalRegOff(outs[14:12]),
    .converterModeSelect(outs[11:7]), .converterSleep(outs[6]), .probeChannel(outs[5:2]),
    .probeMuxEn(outs[1]), .probeBufEn(outs[0])
  );

  function automatic logic [31:0] mkCmd(scfg_row_t r);
    logic [31:0] c;
    c    = {r.tag, r.sel, r.idx, r.wr, r.data, 1'b0};
    c[0] = ^c[31:1] ^ r.badPar;
    return c;
  endfunction

  function automatic logic [18:0] expOuts();
    return {shadow[0][3:0], shadow[0][6:4], shadow[1][4:0], shadow[1][5],
            shadow[2][3:0], shadow[2][4], shadow[2][5]};
  endfunction

  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      numErrors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic runRow(input scfg_row_t r);
    logic [31:0] resp;
    logic [31:0] exp;
    logic        good;
    master.xfer(mkCmd(r), 32, resp);
    exp    = {11'h000, pins, r.ok, r.rd, 1'b0};
    exp[0] = ^exp[31:1];
    if (r.tag === pins) begin
      cmp("response", exp, resp);
    end else begin
      cmp("response flags", 32'(exp[20:17]), 32'(resp[20:17]));
    end
    good = r.tag === pins && r.sel === 4'h0 && !r.badPar && r.idx < 7'h04;
    if (r.wr && good) shadow[r.idx[1:0]] = r.data;
    cmp("register outputs", 32'(expOuts()), 32'(outs));
    cmp("miso idle", 32'h0000_0000, 32'(miso));
  endtask

  task automatic results;
    if (numErrors == 0 && nTests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    #5_000_000;
    numErrors++;
    results();
  end

  initial begin
    logic [31:0] resp;
    for (int i = 0; i < 4; i++) shadow[i] = 16'h0000;
    rows = '{
      '{3'h5, 4'h0, 7'h00, 1'b1, 16'h0123, 1'b0, 16'h0000, 1'b0},
      '{3'h5, 4'h0, 7'h00, 1'b0, 16'h0000, 1'b0, 16'h0123, 1'b1},
      '{3'h5, 4'h0, 7'h01, 1'b1, 16'h0035, 1'b0, 16'h0000, 1'b1},
      '{3'h5, 4'h0, 7'h02, 1'b1, 16'hFFFF, 1'b0, 16'h0000, 1'b1},
      '{3'h5, 4'h0, 7'h03, 1'b1, 16'hA5A5, 1'b0, 16'h0000, 1'b1},
      '{3'h5, 4'h0, 7'h03, 1'b0, 16'h0000, 1'b0, 16'hA5A5, 1'b1},
      '{3'h5, 4'h0, 7'h02, 1'b0, 16'h0000, 1'b0, 16'hFFFF, 1'b1},
      '{3'h5, 4'h0, 7'h01, 1'b1, 16'h0000, 1'b1, 16'h0035, 1'b1},
      '{3'h5, 4'h0, 7'h01, 1'b0, 16'h0000, 1'b0, 16'h0035, 1'b0},
      '{3'h2, 4'h0, 7'h01, 1'b1, 16'h0000, 1'b0, 16'h0000, 1'b1},
      '{3'h5, 4'h0, 7'h01, 1'b0, 16'h0000, 1'b0, 16'h0035, 1'b1},
      '{3'h5, 4'h5, 7'h01, 1'b1, 16'h0000, 1'b0, 16'h0000, 1'b1},
      '{3'h5, 4'h0, 7'h01, 1'b0, 16'h0000, 1'b0, 16'h0035, 1'b1},
      '{3'h5, 4'h0, 7'h7F, 1'b1, 16'h1234, 1'b0, 16'h0000, 1'b1},
      '{3'h5, 4'h0, 7'h7F, 1'b0, 16'h0000, 1'b0, 16'h0000, 1'b1}
    };
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    foreach (rows[i]) runRow(rows[i]);
    // Packet cut short after 20 bits must leave the register alone
    master.xfer(mkCmd('{3'h5, 4'h0, 7'h02, 1'b1, 16'h0001, 1'b0, 16'h0, 1'b0}), 20, resp);
    cmp("outputs after abort", 32'(expOuts()), 32'(outs));
    runRow('{3'h5, 4'h0, 7'h02, 1'b0, 16'h0000, 1'b0, 16'hFFFF, 1'b1});
    // New die tag on the pins
    @(posedge clk_sys);
    pins <= 3'h2;
    repeat (4) @(posedge clk_sys);
    runRow('{3'h2, 4'h0, 7'h00, 1'b1, 16'h007F, 1'b0, 16'h0123, 1'b1});
    // Reset in mid-run clears every register and the status flag
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    for (int i = 0; i < 4; i++) shadow[i] = 16'h0000;
    cmp("outputs after reset", 32'(expOuts()), 32'(outs));
    cmp("miso after reset", 32'h0000_0000, 32'(miso));
    runRow('{3'h2, 4'h0, 7'h03, 1'b0, 16'h0000, 1'b0, 16'h0000, 1'b0});
    results();
  end
endmodule // tb_spi_config_slave_regs
`default_nettype wire
